// file: core/crs_core_regs.v
// Programmer-visible CPU register set with flag update and bank addressing.
// Assumes a single-cycle register port master and synchronous inputs.
//
// Decided for this implementation: the placing of the registers and the address-and-strobe port.
`timescale 1ns/1ps
`include "crs_map.vh"
module crs_core_regs (
  // Clock and reset
  input wire clk_sys,
  input wire nrst,
  // Register port
  input wire [3:0] reg_addr,
  input wire [15:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  output reg [15:0] reg_rdata,
  // Interrupt request
  input wire irq_req,
  input wire [1:0] irq_level,
  output reg irq_take,
  // Derived addresses
  output reg [15:0] gpr_addr
);
  reg [15:0] prog_counter;
  reg [15:0] accumulator;
  reg [15:0] temp_operand;
  reg [15:0] index_reg;
  reg [15:0] extra_pointer;
  reg [15:0] stack_pointer;
  reg [4:0] bank_pointer;
  reg [2:0] bank_hi;
  reg [7:0] cond_code_byte;
  reg [1:0] bank_limit;
  reg [2:0] gpr_sel;
  reg [7:0] alu_result;
  reg [7:0] next_result;
  reg [7:0] next_cc;
  reg next_c;
  reg next_h;
  reg [8:0] wide;
  reg [4:0] nib;
  reg [7:0] a8;
  reg [7:0] b8;
  reg [2:0] op;
  reg cin;
  wire [15:0] program_status_word;
  wire do_op;
  wire [1:0] accept_level_field;
  assign program_status_word = {bank_hi, bank_pointer, cond_code_byte};
  assign do_op = reg_wr && (reg_addr == `CRS_REG_OP);
  assign accept_level_field = {cond_code_byte[`CRS_CC_IL1],
                               cond_code_byte[`CRS_CC_IL0]};

  // Limit the bank pointer to what the variant can address
  function [4:0] crs_bank_mask;
    input [1:0] lim;
    begin
      case (lim)
        `CRS_BANKS_4: crs_bank_mask = `CRS_MASK_4;
        `CRS_BANKS_8: crs_bank_mask = `CRS_MASK_8;
        default: crs_bank_mask = `CRS_MASK_16;
      endcase
    end
  endfunction

  // Byte-wide flag computation from the low bytes of A and T
  always @*
  begin
    a8 = accumulator[7:0];
    b8 = temp_operand[7:0];
    op = reg_wdata[2:0];
    cin = cond_code_byte[`CRS_CC_C];
    wide = 9'h000;
    nib = 5'h00;
    next_c = 1'b0;
    next_h = cond_code_byte[`CRS_CC_H];
    next_result = a8;
    next_cc = cond_code_byte;
    case (op)
      `CRS_OP_ADD, `CRS_OP_ADDC:
      begin
        wide = {1'b0, a8} + {1'b0, b8} +
               {8'h00, (op == `CRS_OP_ADDC) & cin};
        nib = {1'b0, a8[3:0]} + {1'b0, b8[3:0]} +
              {4'h0, (op == `CRS_OP_ADDC) & cin};
        next_result = wide[7:0];
        next_c = wide[8];
        next_h = nib[4];
        next_cc[`CRS_CC_V] = (a8[7] == b8[7]) && (wide[7] != a8[7]);
      end
      `CRS_OP_SUB, `CRS_OP_SUBC:
      begin
        wide = {1'b0, a8} - {1'b0, b8} -
               {8'h00, (op == `CRS_OP_SUBC) & cin};
        nib = {1'b0, a8[3:0]} - {1'b0, b8[3:0]} -
              {4'h0, (op == `CRS_OP_SUBC) & cin};
        next_result = wide[7:0];
        next_c = wide[8];
        next_h = nib[4];
        next_cc[`CRS_CC_V] = (a8[7] != b8[7]) && (wide[7] != a8[7]);
      end
      `CRS_OP_SHL:
      begin
        next_result = {a8[6:0], 1'b0};
        next_c = a8[7];
      end
      `CRS_OP_SHR:
      begin
        next_result = {1'b0, a8[7:1]};
        next_c = a8[0];
      end
      default:
      begin
        next_result = a8;
        next_c = cin;
      end
    endcase
    next_cc[`CRS_CC_H] = next_h;
    next_cc[`CRS_CC_C] = next_c;
    next_cc[`CRS_CC_N] = next_result[7];
    next_cc[`CRS_CC_Z] = (next_result == 8'h00);
  end

  always @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
    begin
      prog_counter <= `CRS_RST_W16;
      accumulator <= `CRS_RST_W16;
      temp_operand <= `CRS_RST_W16;
      index_reg <= `CRS_RST_W16;
      extra_pointer <= `CRS_RST_W16;
      stack_pointer <= `CRS_RST_W16;
      bank_pointer <= 5'h00;
      bank_hi <= 3'h0;
      cond_code_byte <= `CRS_RST_CC;
      bank_limit <= `CRS_BANKS_16;
      gpr_sel <= 3'h0;
      alu_result <= 8'h00;
    end
    else if (do_op)
    begin
      accumulator <= {accumulator[15:8], next_result};
      alu_result <= next_result;
      cond_code_byte <= next_cc;
    end
    else if (reg_wr)
    begin
      case (reg_addr)
        `CRS_REG_PC: prog_counter <= reg_wdata;
        `CRS_REG_ACC: accumulator <= reg_wdata;
        `CRS_REG_TMP: temp_operand <= reg_wdata;
        `CRS_REG_IX: index_reg <= reg_wdata;
        `CRS_REG_EP: extra_pointer <= reg_wdata;
        `CRS_REG_SP: stack_pointer <= reg_wdata;
        `CRS_REG_PSW:
        begin
          bank_hi <= reg_wdata[15:13];
          bank_pointer <= reg_wdata[12:8] & crs_bank_mask(bank_limit);
          cond_code_byte <= reg_wdata[7:0];
        end
        `CRS_REG_GPA: gpr_sel <= reg_wdata[2:0];
        `CRS_REG_CFG:
        begin
          bank_limit <= reg_wdata[1:0];
          bank_pointer <= bank_pointer & crs_bank_mask(reg_wdata[1:0]);
        end
        default:
        begin
          gpr_sel <= gpr_sel;
        end
      endcase
    end
  end

  // Outputs registered; reads answer one cycle after the strobe
  always @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
    begin
      reg_rdata <= `CRS_RST_W16;
      irq_take <= 1'b0;
      gpr_addr <= `CRS_RST_W16;
    end
    else
    begin
      irq_take <= irq_req && cond_code_byte[`CRS_CC_I] &&
                  (irq_level < accept_level_field);
      gpr_addr <= {`CRS_GPR_PREFIX, bank_pointer, gpr_sel};
      if (reg_rd)
      begin
        case (reg_addr)
          `CRS_REG_PC: reg_rdata <= prog_counter;
          `CRS_REG_ACC: reg_rdata <= accumulator;
          `CRS_REG_TMP: reg_rdata <= temp_operand;
          `CRS_REG_IX: reg_rdata <= index_reg;
          `CRS_REG_EP: reg_rdata <= extra_pointer;
          `CRS_REG_SP: reg_rdata <= stack_pointer;
          `CRS_REG_PSW: reg_rdata <= program_status_word;
          `CRS_REG_GPA: reg_rdata <= {13'h0000, gpr_sel};
          `CRS_REG_CFG: reg_rdata <= {14'h0000, bank_limit};
          `CRS_REG_RES: reg_rdata <= {8'h00, alu_result};
          default: reg_rdata <= `CRS_RST_W16;
        endcase
      end
      else
      begin
        reg_rdata <= `CRS_RST_W16;
      end
    end
  end
endmodule

// file: pkg/crs_map.vh
// Register map, field positions and reset values of the core register set.
// Assumes inclusion by bare name from the core file.
`ifndef CRS_MAP_VH
`define CRS_MAP_VH
`define CRS_ADDR_W 4
`define CRS_REG_PC 4'h0
`define CRS_REG_ACC 4'h1
`define CRS_REG_TMP 4'h2
`define CRS_REG_IX 4'h3
`define CRS_REG_EP 4'h4
`define CRS_REG_SP 4'h5
`define CRS_REG_PSW 4'h6
`define CRS_REG_OP 4'h7
`define CRS_REG_GPA 4'h8
`define CRS_REG_CFG 4'h9
`define CRS_REG_RES 4'ha
// Condition code bit positions
`define CRS_CC_C 0
`define CRS_CC_V 1
`define CRS_CC_Z 2
`define CRS_CC_N 3
`define CRS_CC_IL0 4
`define CRS_CC_IL1 5
`define CRS_CC_I 6
`define CRS_CC_H 7
// Operation codes
`define CRS_OP_ADD 3'h0
`define CRS_OP_SUB 3'h1
`define CRS_OP_ADDC 3'h2
`define CRS_OP_SUBC 3'h3
`define CRS_OP_SHL 3'h4
`define CRS_OP_SHR 3'h5
// Bank limit codes
`define CRS_BANKS_4 2'h0
`define CRS_BANKS_8 2'h1
`define CRS_BANKS_16 2'h2
`define CRS_MASK_4 5'h03
`define CRS_MASK_8 5'h07
`define CRS_MASK_16 5'h0f
`define CRS_GPR_PREFIX 8'h01
`define CRS_RST_CC 8'h30
`define CRS_RST_W16 16'h0000
`define CRS_LVL_LOWEST 2'h3
`endif

// file: bench/crs_core_regs_assertions.sv
// Port assertions for the core register set.
// Assumes a bind onto crs_core_regs.
`timescale 1ns/1ps
module crs_chk (
  // Clock, reset, register port
  input wire clk_sys,
  input wire nrst,
  input wire [3:0] reg_addr,
  input wire [15:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  input wire [15:0] reg_rdata,
  // Interrupt, derived address
  input wire irq_req,
  input wire [1:0] irq_level,
  input wire irq_take,
  input wire [15:0] gpr_addr
);
  reg seen;
  reg [1:0] lim;
  wire [4:0] msk = lim == 2'h0 ? 5'h03 : lim == 2'h1 ? 5'h07 : 5'h0f;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!nrst);
  // Tracks status writes to know when irq_take may rise, and the bank limit to know what gpr_addr may show
  always @(posedge clk_sys or negedge nrst)
    if (!nrst)
    begin
      seen <= 1'b0;
      lim <= 2'h2;
    end
    else if (reg_wr)
    begin
      seen <= seen | reg_addr == 4'h6;
      if (reg_addr == 4'h9)
        lim <= reg_wdata[1:0];
    end
  property p_ri; !reg_rd |=> reg_rdata == 16'h0000; endproperty
  a_ri: assert property (p_ri) else $error("rdata idle");
  property p_wr;
    reg_wr && reg_addr < 4'h6 ##1 reg_rd && reg_addr == $past(reg_addr)
    |=> reg_rdata == $past(reg_wdata, 2);
  endproperty
  a_wr: assert property (p_wr) else $error("readback");
  property p_gp; $past(nrst) |-> gpr_addr[15:8] == 8'h01; endproperty
  a_gp: assert property (p_gp) else $error("gpr prefix");
  property p_gh;
    $past(nrst) && $past(nrst, 2) && !$past(reg_wr, 2) |-> $stable(gpr_addr);
  endproperty
  a_gh: assert property (p_gh) else $error("gpr moved");
  property p_bk; lim == $past(lim) |-> (gpr_addr[7:3] & ~msk) == 0; endproperty
  a_bk: assert property (p_bk) else $error("bank limit");
  property p_il;
    irq_take |-> $past(irq_req) && $past(irq_level) != 2'h3;
  endproperty
  a_il: assert property (p_il) else $error("irq level");
  property p_io; !seen |-> !irq_take; endproperty
  a_io: assert property (p_io) else $error("irq at reset");
  property p_um; reg_rd && reg_addr > 4'ha |=> reg_rdata == 0; endproperty
  a_um: assert property (p_um) else $error("unmapped");
  c_wr: cover property (p_wr);
  c_it: cover property (irq_take);
  c_b4: cover property (lim == 2'h0);
endmodule

// file: bench/crs_core_regs_test.sv
// Self-checking bench for the core register set.
// Assumes the checker module is compiled first.
`timescale 1ns/1ps
module crs_core_regs_test;
  reg clk_sys, nrst, reg_wr, reg_rd, irq_req;
  reg [3:0] reg_addr;
  reg [15:0] reg_wdata, a, t, e;
  reg [1:0] irq_level;
  wire [15:0] reg_rdata, gpr_addr;
  wire irq_take;
  integer fail_count, checked, i, j;
  crs_core_regs dut (.clk_sys(clk_sys), .nrst(nrst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .irq_req(irq_req), .irq_level(irq_level),
    .irq_take(irq_take), .gpr_addr(gpr_addr));
  initial
  begin
    clk_sys = 1'b0;
    forever #50 clk_sys = ~clk_sys;
  end
  task chk(input [39:0] n, input [15:0] s, x);
  begin
    checked = checked + 1;
    if (s !== x)
    begin
      fail_count = fail_count + 1;
      $display("[ERR] %s exp %h seen %h", n, x, s);
    end
  end
  endtask
  task bus(input w, input [3:0] ad, input [15:0] d);
  begin
    reg_wr <= w;
    reg_rd <= !w;
    reg_addr <= ad;
    reg_wdata <= d;
    @(posedge clk_sys);
  end
  endtask
  task rd(input [3:0] ad, input [15:0] x);
  begin
    bus(1'b0, ad, 16'h0000);
    reg_rd <= 1'b0;
    #10 chk("rdata", reg_rdata, x);
    @(posedge clk_sys);
  end
  endtask
  // Returns expected flags above the byte result; subtract as inverted add
  function [15:0] alu(input [2:0] op, input [7:0] x, y, f);
    reg [8:0] s;
    reg [4:0] h;
    reg [7:0] q, yy;
    reg ci;
    begin
      q = f;
      if (op > 3'h5)
      begin
        s = {f[0], x};
        q[0] = s[8];
      end
      else if (op > 3'h3)
      begin
        s = op[0] ? {x[0], 1'b0, x[7:1]} : {x, 1'b0};
        q[0] = s[8];
      end
      else
      begin
        yy = op[0] ? ~y : y;
        ci = op[0] ^ (op[1] & f[0]);
        s = x + yy + ci;
        h = x[3:0] + yy[3:0] + ci;
        q[0] = s[8] ^ op[0];
        q[1] = x[7] == yy[7] && s[7] != x[7];
        q[7] = h[4] ^ op[0];
      end
      q[3] = s[7];
      q[2] = s[7:0] == 8'h00;
      alu = {q, s[7:0]};
    end
  endfunction
  task end_sim;
  begin
    $display("checks %0d mismatches %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  end
  endtask
  initial
  begin
    #600000;
    fail_count = fail_count + 1;
    end_sim;
  end
  initial
  begin
    {nrst, reg_wr, reg_rd, irq_req, irq_level, reg_addr, reg_wdata} = '0;
    fail_count = 0;
    checked = 0;
    e = $urandom(97390);
    repeat (20) @(posedge clk_sys);
    nrst <= 1'b1;
    for (i = 0; i < 6; i = i + 1)
      rd(i[3:0], 16'h0000);
    rd(4'h6, 16'h0030);
    rd(4'hf, 16'h0000);
    chk("gpr", gpr_addr, 16'h0100);
    for (i = 0; i < 12; i = i + 1)
    begin
      e = $urandom;
      bus(1'b1, i % 6, e);
      rd(i % 6, e);
    end
    $display("reset and readback done");
    for (j = 0; j < 3; j = j + 1)
      for (i = 0; i < 4; i = i + 1)
      begin
        e = $urandom;
        a = $urandom;
        bus(1'b1, 4'h9, j);
        bus(1'b1, 4'h6, e);
        bus(1'b1, 4'h8, a);
        e[12:8] = e[12:8] & (j == 0 ? 5'h03 : j == 1 ? 5'h07 : 5'h0f);
        rd(4'h6, e);
        rd(4'h8, {13'h0000, a[2:0]});
        rd(4'h9, j);
        chk("gpr", gpr_addr, {8'h01, e[12:8], a[2:0]});
      end
    $display("bank test done");
    for (i = 0; i < 32; i = i + 1)
    begin
      a = $urandom;
      t = $urandom;
      e = $urandom;
      if (i < 12)
        {a[7:0], t[7:0]} = i < 6 ? 16'h7f01 : 16'hff01;
      bus(1'b1, 4'h1, a);
      bus(1'b1, 4'h2, t);
      bus(1'b1, 4'h6, {8'h00, e[7:0]});
      bus(1'b1, 4'h7, i % 8);
      e = alu(i % 8, a[7:0], t[7:0], e[7:0]);
      rd(4'h1, {a[15:8], e[7:0]});
      rd(4'ha, {8'h00, e[7:0]});
      rd(4'h6, {8'h00, e[15:8]});
    end
    $display("flag test done");
    for (i = 0; i < 64; i = i + 1)
    begin
      bus(1'b1, 4'h6, {9'h000, i[4], i[1:0], 4'h0});
      irq_req <= i[5];
      irq_level <= i[3:2];
      reg_wr <= 1'b0;
      @(posedge clk_sys);
      #10 chk("take", irq_take, i[5] & i[4] & (i[3:2] < i[1:0]));
      @(posedge clk_sys);
    end
    $display("irq test done");
    end_sim;
  end
endmodule
bind crs_core_regs crs_chk chk_i (.clk_sys(clk_sys), .nrst(nrst),
  .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
  .reg_rd(reg_rd), .reg_rdata(reg_rdata), .irq_req(irq_req),
  .irq_level(irq_level), .irq_take(irq_take), .gpr_addr(gpr_addr));
